// ---- core/i2cscp_target.sv ----
// target end: start/stop detect, address match, ack, register strobes
`default_nettype none
module i2cscp_target
	import i2cscp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	i2cscp_if.target         bus,
	input  wire logic        sleepOrAddrSel,
	output logic [7:0]       regAddr,
	output logic [7:0]       regWrData,
	output logic             regWrStb,
	output logic             regRdStb,
	input  wire logic [7:0]  regRdData,
	output logic             busy
);
	import i2cscp_pkg::*;
	logic [2:0] sclSync_r, sclSync_nxt;
	logic [2:0] sdaSync_r, sdaSync_nxt;
	logic [1:0] strapSync_r, strapSync_nxt;
	logic       strapDone_r, strapDone_nxt;
	logic       addrLsb_r, addrLsb_nxt;
	i2cscp_dstate_t st_r, st_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] txByte_r, txByte_nxt;
	logic       dirRead_r, dirRead_nxt;
	logic       acking_r, acking_nxt;
	logic       sdaOe_r, sdaOe_nxt;
	logic [7:0] regAddr_r, regAddr_nxt;
	logic [7:0] wrData_r, wrData_nxt;
	logic       wrStb_r, wrStb_nxt;
	logic       rdStb_r, rdStb_nxt;
	logic       busy_r, busy_nxt;
	logic       sclRise, sclFall, startSeen, stopSeen;
	logic [6:0] myAddr;

	// bit 0 is first stage, only copied onward
	assign sclRise   = sclSync_r[1] & ~sclSync_r[2];
	assign sclFall   = ~sclSync_r[1] & sclSync_r[2];
	assign startSeen = sclSync_r[1] & sclSync_r[2] & ~sdaSync_r[1] & sdaSync_r[2];
	assign stopSeen  = sclSync_r[1] & sclSync_r[2] & sdaSync_r[1] & ~sdaSync_r[2];
	assign myAddr    = {ADDR_UPPER, addrLsb_r};

	always_comb
	begin
		sclSync_nxt   = {sclSync_r[1:0], bus.scl};
		sdaSync_nxt   = {sdaSync_r[1:0], bus.sda};
		strapSync_nxt = {strapSync_r[0], sleepOrAddrSel};
		strapDone_nxt = 1'b1;
		addrLsb_nxt   = addrLsb_r;
		// caught once after reset release, then frozen
		if (!strapDone_r)
			addrLsb_nxt = strapSync_r[1];
		st_nxt      = st_r;
		bitCnt_nxt  = bitCnt_r;
		shift_nxt   = shift_r;
		txByte_nxt  = txByte_r;
		dirRead_nxt = dirRead_r;
		acking_nxt  = acking_r;
		sdaOe_nxt   = sdaOe_r;
		regAddr_nxt = regAddr_r;
		wrData_nxt  = wrData_r;
		wrStb_nxt   = 1'b0;
		rdStb_nxt   = 1'b0;
		busy_nxt    = (st_r != DS_IDLE) && (st_r != DS_IGN);
		if (startSeen)
		begin
			st_nxt     = DS_ADDR;
			// one below zero: the scl fall after start carries no data bit
			bitCnt_nxt = BIT_CNT_RESET - 4'h1;
			acking_nxt = 1'b0;
			sdaOe_nxt  = 1'b0;
		end
		else if (stopSeen)
		begin
			st_nxt    = DS_IDLE;
			sdaOe_nxt = 1'b0;
		end
		else if (st_r != DS_IDLE && st_r != DS_IGN)
		begin
			if (sclRise && bitCnt_r < ACK_SLOT)
				shift_nxt = {shift_r[6:0], sdaSync_r[1]};
			if (sclRise && bitCnt_r == ACK_SLOT && st_r == DS_RDAT)
			begin
				// master nack ends the read; ack keeps it going
				if (sdaSync_r[1])
					st_nxt = DS_IGN;
			end
			if (sclFall)
			begin
				// all drive changes land on falling scl, never while high
				if (bitCnt_r == 4'h7)
				begin
					bitCnt_nxt = ACK_SLOT;
					case (st_r)
						DS_ADDR:
						begin
							if (shift_r[7:1] == myAddr)
							begin
								dirRead_nxt = shift_r[0];
								acking_nxt  = 1'b1;
								sdaOe_nxt   = 1'b1;
							end
							else
								st_nxt = DS_IGN;
						end
						DS_RADR, DS_WDAT:
						begin
							acking_nxt = 1'b1;
							sdaOe_nxt  = 1'b1;
						end
						DS_RDAT: sdaOe_nxt = 1'b0;
						default: sdaOe_nxt = 1'b0;
					endcase
				end
				else if (bitCnt_r == ACK_SLOT)
				begin
					bitCnt_nxt = BIT_CNT_RESET;
					acking_nxt = 1'b0;
					sdaOe_nxt  = 1'b0;
					case (st_r)
						DS_ADDR:
						begin
							if (dirRead_r == DIR_READ)
							begin
								st_nxt     = DS_RDAT;
								txByte_nxt = regRdData;
								rdStb_nxt  = 1'b1;
								sdaOe_nxt  = ~regRdData[7];
							end
							else
								st_nxt = DS_RADR;
						end
						DS_RADR:
						begin
							regAddr_nxt = shift_r;
							st_nxt      = DS_WDAT;
						end
						DS_WDAT:
						begin
							wrData_nxt  = shift_r;
							wrStb_nxt   = 1'b1;
							regAddr_nxt = regAddr_r + 8'h01;
						end
						DS_RDAT:
						begin
							// pointer steps after each acked read byte; txByte is not reloaded for a following byte
							regAddr_nxt = regAddr_r + 8'h01;
							st_nxt      = DS_RDAT;
						end
						default: st_nxt = st_r;
					endcase
				end
				else
				begin
					bitCnt_nxt = bitCnt_r + 4'h1;
					if (st_r == DS_RDAT)
					begin
						txByte_nxt = {txByte_r[6:0], 1'b0};
						sdaOe_nxt  = ~txByte_r[6];
					end
				end
			end
		end
		if (st_r == DS_RDAT && wrStb_r == 1'b0 && rdStb_r)
			txByte_nxt = txByte_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclSync_r   <= 3'h7;
			sdaSync_r   <= 3'h7;
			// keeps sampling through reset so release sees a settled strap
			strapSync_r <= strapSync_nxt;
			strapDone_r <= 1'b0;
			addrLsb_r   <= 1'b0;
			st_r        <= DS_IDLE;
			bitCnt_r    <= BIT_CNT_RESET;
			shift_r     <= BYTE_RESET;
			txByte_r    <= BYTE_RESET;
			dirRead_r   <= DIR_WRITE;
			acking_r    <= 1'b0;
			sdaOe_r     <= 1'b0;
			regAddr_r   <= BYTE_RESET;
			wrData_r    <= BYTE_RESET;
			wrStb_r     <= 1'b0;
			rdStb_r     <= 1'b0;
			busy_r      <= 1'b0;
		end
		else
		begin
			sclSync_r   <= sclSync_nxt;
			sdaSync_r   <= sdaSync_nxt;
			strapSync_r <= strapSync_nxt;
			strapDone_r <= strapDone_nxt;
			addrLsb_r   <= addrLsb_nxt;
			st_r        <= st_nxt;
			bitCnt_r    <= bitCnt_nxt;
			shift_r     <= shift_nxt;
			txByte_r    <= txByte_nxt;
			dirRead_r   <= dirRead_nxt;
			acking_r    <= acking_nxt;
			sdaOe_r     <= sdaOe_nxt;
			regAddr_r   <= regAddr_nxt;
			wrData_r    <= wrData_nxt;
			wrStb_r     <= wrStb_nxt;
			rdStb_r     <= rdStb_nxt;
			busy_r      <= busy_nxt;
		end
	end

	// target only: never touches scl
	assign bus.sdaSO  = 1'b0;
	assign bus.sdaSOe = sdaOe_r;
	assign regAddr    = regAddr_r;
	assign regWrData  = wrData_r;
	assign regWrStb   = wrStb_r;
	assign regRdStb   = rdStb_r;
	assign busy       = busy_r;
endmodule
`default_nettype wire

// ---- core/i2cscp_pkg.sv ----
// shared constants and types for the two-wire control port
`default_nettype none
package i2cscp_pkg;
	localparam logic [5:0] ADDR_UPPER      = 6'h36;
	localparam int         CLK_HZ          = 100000000;
	localparam int         SCL_STD_HZ      = 100000;
	localparam int         SCL_FAST_HZ     = 400000;
	localparam int         HALF_STD_CYC    = CLK_HZ / (2 * SCL_STD_HZ);
	localparam int         HALF_FAST_CYC   = CLK_HZ / (2 * SCL_FAST_HZ);
	localparam logic [3:0] BIT_CNT_RESET   = 4'h0;
	localparam logic [3:0] ACK_SLOT        = 4'h8;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	localparam logic       DIR_WRITE       = 1'b0;
	localparam logic       DIR_READ        = 1'b1;
	typedef enum logic [2:0]
	{
		DS_IDLE  = 3'b000,
		DS_ADDR  = 3'b001,
		DS_RADR  = 3'b010,
		DS_WDAT  = 3'b011,
		DS_RDAT  = 3'b100,
		DS_IGN   = 3'b101
	} i2cscp_dstate_t;
	typedef enum logic [3:0]
	{
		HS_IDLE  = 4'b0000,
		HS_START = 4'b0001,
		HS_LOW   = 4'b0010,
		HS_HIGH  = 4'b0011,
		HS_RSTA  = 4'b0100,
		HS_RSTB  = 4'b0101,
		HS_STOPA = 4'b0110,
		HS_STOPB = 4'b0111,
		HS_STOPC = 4'b1000
	} i2cscp_hstate_t;
endpackage
`default_nettype wire

// ---- core/i2cscp_if.sv ----
// two-wire bus between master and target, wired-and with pull-ups
`default_nettype none
interface i2cscp_if;
	logic sclO;
	logic sclOe;
	logic sdaMO;
	logic sdaMOe;
	logic sdaSO;
	logic sdaSOe;
	logic scl;
	logic sda;
	// open drain: any enabled driver pulls low
	assign scl = ~(sclOe & ~sclO);
	assign sda = ~((sdaMOe & ~sdaMO) | (sdaSOe & ~sdaSO));
	modport master (output sclO, output sclOe, output sdaMO, output sdaMOe,
		input scl, input sda);
	modport target (output sdaSO, output sdaSOe, input scl, input sda);
endinterface
`default_nettype wire

// ---- core/i2cscp_master.sv ----
// master end: issues single-byte register write or combined read
`default_nettype none
module i2cscp_master
	import i2cscp_pkg::*;
#(
	parameter int HALF_CYC = HALF_FAST_CYC
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	i2cscp_if.master         bus,
	input  wire logic        reqValid,
	input  wire logic        reqRead,
	input  wire logic [6:0]  reqDevAddr,
	input  wire logic [7:0]  reqRegAddr,
	input  wire logic [7:0]  reqWrData,
	output logic             reqReady,
	output logic             doneStb,
	output logic             nackErr,
	output logic [7:0]       rdData
);
	import i2cscp_pkg::*;
	i2cscp_hstate_t st_r, st_nxt;
	logic [15:0] tick_r, tick_nxt;
	logic [3:0]  bitCnt_r, bitCnt_nxt;
	logic [1:0]  byteIdx_r, byteIdx_nxt;
	logic [7:0]  tx_r, tx_nxt;
	logic [7:0]  rx_r, rx_nxt;
	logic        read_r, read_nxt;
	logic [6:0]  dev_r, dev_nxt;
	logic [7:0]  reg_r, reg_nxt;
	logic [7:0]  dat_r, dat_nxt;
	logic        scl_r, scl_nxt;
	logic        sdaOe_r, sdaOe_nxt;
	logic        done_r, done_nxt;
	logic        nack_r, nack_nxt;
	logic [1:0]  sdaSync_r, sdaSync_nxt;
	logic        tickEnd;
	logic        lastByte;

	assign tickEnd  = (tick_r == 16'(HALF_CYC - 1));
	assign lastByte = read_r ? (byteIdx_r == 2'h3) : (byteIdx_r == 2'h2);

	always_comb
	begin
		st_nxt      = st_r;
		tick_nxt    = tickEnd ? 16'h0000 : tick_r + 16'h0001;
		bitCnt_nxt  = bitCnt_r;
		byteIdx_nxt = byteIdx_r;
		tx_nxt      = tx_r;
		rx_nxt      = rx_r;
		read_nxt    = read_r;
		dev_nxt     = dev_r;
		reg_nxt     = reg_r;
		dat_nxt     = dat_r;
		scl_nxt     = scl_r;
		sdaOe_nxt   = sdaOe_r;
		done_nxt    = 1'b0;
		nack_nxt    = nack_r;
		sdaSync_nxt = {sdaSync_r[0], bus.sda};
		case (st_r)
			HS_IDLE:
			begin
				tick_nxt = 16'h0000;
				if (reqValid)
				begin
					read_nxt    = reqRead;
					dev_nxt     = reqDevAddr;
					reg_nxt     = reqRegAddr;
					dat_nxt     = reqWrData;
					nack_nxt    = 1'b0;
					byteIdx_nxt = 2'h0;
					bitCnt_nxt  = BIT_CNT_RESET;
					tx_nxt      = {reqDevAddr, DIR_WRITE};
					sdaOe_nxt   = 1'b1;
					st_nxt      = HS_START;
				end
			end
			HS_START: if (tickEnd)
			begin
				scl_nxt   = 1'b0;
				sdaOe_nxt = ~tx_r[7];
				st_nxt    = HS_LOW;
			end
			HS_LOW: if (tickEnd)
			begin
				scl_nxt = 1'b1;
				st_nxt  = HS_HIGH;
			end
			HS_HIGH: if (tickEnd)
			begin
				scl_nxt = 1'b0;
				st_nxt  = HS_LOW;
				if (bitCnt_r < ACK_SLOT)
				begin
					rx_nxt     = {rx_r[6:0], sdaSync_r[1]};
					tx_nxt     = {tx_r[6:0], 1'b1};
					bitCnt_nxt = bitCnt_r + 4'h1;
					// release for the target's ack; on the read byte this is the nack
					if (bitCnt_r == 4'h7)
						sdaOe_nxt = 1'b0;
					else
						sdaOe_nxt = ~tx_r[6];
				end
				else
				begin
					bitCnt_nxt  = BIT_CNT_RESET;
					byteIdx_nxt = byteIdx_r + 2'h1;
					if (byteIdx_r != 2'h3 && sdaSync_r[1])
					begin
						nack_nxt  = 1'b1;
						sdaOe_nxt = 1'b1;
						st_nxt    = HS_STOPA;
					end
					else if (lastByte)
					begin
						sdaOe_nxt = 1'b1;
						st_nxt    = HS_STOPA;
					end
					else if (byteIdx_r == 2'h1 && read_r)
					begin
						sdaOe_nxt = 1'b0;
						tx_nxt    = {dev_r, DIR_READ};
						st_nxt    = HS_RSTA;
					end
					else
					begin
						tx_nxt    = (byteIdx_r == 2'h0) ? reg_r : dat_r;
						sdaOe_nxt = (byteIdx_r == 2'h0) ? ~reg_r[7] : ~dat_r[7];
						// read byte: all ones keeps sda released while the target sends
						if (byteIdx_r == 2'h2)
						begin
							tx_nxt    = 8'hFF;
							sdaOe_nxt = 1'b0;
						end
					end
				end
			end
			HS_RSTA: if (tickEnd)
			begin
				scl_nxt = 1'b1;
				st_nxt  = HS_RSTB;
			end
			HS_RSTB: if (tickEnd)
			begin
				sdaOe_nxt = 1'b1;
				st_nxt    = HS_START;
			end
			HS_STOPA: if (tickEnd)
			begin
				scl_nxt = 1'b1;
				st_nxt  = HS_STOPB;
			end
			HS_STOPB: if (tickEnd)
			begin
				sdaOe_nxt = 1'b0;
				st_nxt    = HS_STOPC;
			end
			HS_STOPC: if (tickEnd)
			begin
				done_nxt = 1'b1;
				st_nxt   = HS_IDLE;
			end
			default: st_nxt = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r      <= HS_IDLE;
			tick_r    <= 16'h0000;
			bitCnt_r  <= BIT_CNT_RESET;
			byteIdx_r <= 2'h0;
			tx_r      <= BYTE_RESET;
			rx_r      <= BYTE_RESET;
			read_r    <= DIR_WRITE;
			dev_r     <= 7'h00;
			reg_r     <= BYTE_RESET;
			dat_r     <= BYTE_RESET;
			scl_r     <= 1'b1;
			sdaOe_r   <= 1'b0;
			done_r    <= 1'b0;
			nack_r    <= 1'b0;
			sdaSync_r <= 2'h3;
		end
		else
		begin
			st_r      <= st_nxt;
			tick_r    <= tick_nxt;
			bitCnt_r  <= bitCnt_nxt;
			byteIdx_r <= byteIdx_nxt;
			tx_r      <= tx_nxt;
			rx_r      <= rx_nxt;
			read_r    <= read_nxt;
			dev_r     <= dev_nxt;
			reg_r     <= reg_nxt;
			dat_r     <= dat_nxt;
			scl_r     <= scl_nxt;
			sdaOe_r   <= sdaOe_nxt;
			done_r    <= done_nxt;
			nack_r    <= nack_nxt;
			sdaSync_r <= sdaSync_nxt;
		end
	end

	assign bus.sclO   = 1'b0;
	assign bus.sclOe  = ~scl_r;
	assign bus.sdaMO  = 1'b0;
	assign bus.sdaMOe = sdaOe_r;
	assign reqReady   = (st_r == HS_IDLE);
	assign doneStb    = done_r;
	assign nackErr    = nack_r;
	assign rdData     = rx_r;
endmodule
`default_nettype wire

// ---- sim/i2cscp_asserts.sv ----
// concurrent checks on the two-wire bus between master and target
`default_nettype none
module i2cscp_asserts
#(
	parameter int HALF_CYC = 125
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sclO,
	input  wire logic sclOe,
	input  wire logic sdaMO,
	input  wire logic sdaMOe,
	input  wire logic sdaSO,
	input  wire logic sdaSOe,
	input  wire logic scl,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] lowCnt_r;
	logic [12:0] lowCnt_nxt;

	// length of the current scl low phase
	always_comb
	begin
		lowCnt_nxt = scl ? 13'h0000 : lowCnt_r + 13'h0001;
	end

	always_ff @(posedge clk)
	begin
		lowCnt_r <= rst ? 13'h0000 : lowCnt_nxt;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence start_s;
		scl && $past(scl) && $fell(sda);
	endsequence

	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence

	sequence fall_s;
		$fell(scl);
	endsequence

	tgt_open_drain_a: assert property (sdaSOe |-> !sdaSO)
		else $error("target drives sda high");
	mst_open_drain_a: assert property ((sclOe |-> !sclO) and (sdaMOe |-> !sdaMO))
		else $error("master drives a line high");
	scl_master_only_a: assert property (scl == !sclOe)
		else $error("scl not following the master");
	tgt_change_low_a: assert property ($changed(sdaSOe) |-> !scl && !$past(scl))
		else $error("target moved sda while scl high");
	ack_whole_high_a: assert property ($rose(scl) && sdaSOe |-> sdaSOe throughout (##[1:600] fall_s))
		else $error("target released sda during scl high");
	start_then_low_a: assert property (start_s |-> ##[1:600] !scl)
		else $error("no clock after start");
	mst_rise_stable_a: assert property ($rose(scl) |-> $stable(sdaMOe))
		else $error("master moved sda at scl rise");
	stop_release_a: assert property (stop_s |=> !sdaSOe [*8])
		else $error("target holds sda after stop");
	low_bounded_a: assert property (int'(lowCnt_r) <= 4 * HALF_CYC)
		else $error("scl low phase too long");
endmodule
`default_nettype wire

// ---- sim/i2c_slave_control_port_test.sv ----
// self-checking bench: fast-mode master joined to the target
`default_nettype none
module i2c_slave_control_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	import i2cscp_pkg::*;

	logic       clk;
	logic       rst;
	logic       strap;
	logic       reqValid;
	logic       reqRead;
	logic [6:0] reqDevAddr;
	logic [7:0] reqRegAddr;
	logic [7:0] reqWrData;
	logic       reqReady;
	logic       doneStb;
	logic       nackErr;
	logic [7:0] rdData;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic [7:0] prevAddr;
	logic       regWrStb;
	logic       regRdStb;
	logic       busy;
	logic       sclQ;
	logic       sdaQ;
	logic [3:0] bitCnt;
	logic [8:0] firstWord;
	logic [7:0] mem [256];
	int         wrCnt;
	int         rdCnt;
	int         nFail;
	int         checkCount;
	int         cyc;

	i2cscp_if i2cscp_if_i();

	i2cscp_master #(.HALF_CYC(HALF_FAST_CYC)) i2cscp_master_i (.clk(clk), .rst(rst),
		.bus(i2cscp_if_i), .reqValid(reqValid), .reqRead(reqRead), .reqDevAddr(reqDevAddr),
		.reqRegAddr(reqRegAddr), .reqWrData(reqWrData), .reqReady(reqReady),
		.doneStb(doneStb), .nackErr(nackErr), .rdData(rdData));

	i2cscp_target i2cscp_target_i (.clk(clk), .rst(rst), .bus(i2cscp_if_i),
		.sleepOrAddrSel(strap), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .busy(busy));

	i2cscp_asserts #(.HALF_CYC(HALF_FAST_CYC)) i2cscp_asserts_i (.clk(clk), .rst(rst),
		.sclO(i2cscp_if_i.sclO), .sclOe(i2cscp_if_i.sclOe), .sdaMO(i2cscp_if_i.sdaMO),
		.sdaMOe(i2cscp_if_i.sdaMOe), .sdaSO(i2cscp_if_i.sdaSO),
		.sdaSOe(i2cscp_if_i.sdaSOe), .scl(i2cscp_if_i.scl), .sda(i2cscp_if_i.sda));

	// register bank; address taken a cycle early since the pointer steps on write
	assign regRdData = mem[regAddr];

	always @(posedge clk)
	begin
		prevAddr <= regAddr;
		sclQ <= i2cscp_if_i.scl;
		sdaQ <= i2cscp_if_i.sda;
		cyc <= cyc + 1;
		if (regWrStb)
		begin
			mem[prevAddr] <= regWrData;
			wrCnt <= wrCnt + 1;
		end
		if (regRdStb)
			rdCnt <= rdCnt + 1;
		// first nine bits after each start, ack included
		if (sclQ && i2cscp_if_i.scl && sdaQ && !i2cscp_if_i.sda)
			bitCnt <= 4'h0;
		else if (!sclQ && i2cscp_if_i.scl && bitCnt < 4'h9)
		begin
			firstWord <= {firstWord[7:0], i2cscp_if_i.sda};
			bitCnt <= bitCnt + 4'h1;
		end
		if (cyc == 80000)
		begin
			nFail = nFail + 1;
			wrap_up;
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wrap_up;
		if (nFail == 0 && checkCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			nFail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_val({8'h00, got}, {8'h00, exp});
	endtask

	task automatic do_reset(input logic s);
		rst <= 1'b1;
		strap <= s;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
	endtask

	// one whole request; returns at the edge that shows the done pulse
	task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] ra,
		input logic [7:0] wd);
		int n;
		reqValid <= 1'b1;
		reqRead <= rd;
		reqDevAddr <= dev;
		reqRegAddr <= ra;
		reqWrData <= wd;
		@(posedge clk);
		check_bit(reqReady, 1'b1);
		reqValid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (doneStb !== 1'b1 && n < 20000);
		check_bit(doneStb, 1'b1);
	endtask

	task automatic wr_rd_low;
		int w;
		int r;
		w = wrCnt;
		r = rdCnt;
		xfer(1'b0, 7'h6C, 8'h05, 8'hA5);
		check_bit(nackErr, 1'b0);
		check_val(firstWord, 9'h1B0);
		check_val(9'(wrCnt - w), 9'h001);
		check_val({1'b0, mem[8'h05]}, 9'h0A5);
		xfer(1'b1, 7'h6C, 8'h05, 8'h00);
		check_bit(nackErr, 1'b0);
		check_val(9'(rdCnt - r), 9'h001);
		check_bit(busy, 1'b0);
		check_val({1'b0, rdData}, 9'h0A5);
		check_val(firstWord, 9'h1B2);
	endtask

	task automatic wrong_addr;
		int w;
		w = wrCnt;
		xfer(1'b0, 7'h6D, 8'h06, 8'h11);
		check_bit(nackErr, 1'b1);
		check_val(firstWord, 9'h1B5);
		check_val(9'(wrCnt - w), 9'h000);
		xfer(1'b1, 7'h6D, 8'h05, 8'h00);
		check_bit(nackErr, 1'b1);
	endtask

	// strap moves without a power up: address must not follow
	task automatic strap_late;
		strap <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(1'b0, 7'h6C, 8'hFF, 8'h3C);
		check_bit(nackErr, 1'b0);
		check_val({1'b0, mem[8'hFF]}, 9'h03C);
		xfer(1'b1, 7'h6D, 8'hFF, 8'h00);
		check_bit(nackErr, 1'b1);
	endtask

	task automatic strap_high;
		do_reset(1'b1);
		xfer(1'b0, 7'h6D, 8'h00, 8'h5A);
		check_bit(nackErr, 1'b0);
		xfer(1'b1, 7'h6D, 8'h00, 8'h00);
		check_val({1'b0, rdData}, 9'h05A);
		xfer(1'b0, 7'h6C, 8'h01, 8'h77);
		check_bit(nackErr, 1'b1);
	endtask

	initial
	begin
		rst = 1'b1;
		strap = 1'b0;
		reqValid = 1'b0;
		reqRead = 1'b0;
		reqDevAddr = 7'h00;
		reqRegAddr = 8'h00;
		reqWrData = 8'h00;
		nFail = 0;
		checkCount = 0;
		cyc = 0;
		wrCnt = 0;
		rdCnt = 0;
		bitCnt = 4'h0;
		firstWord = 9'h000;
		@(posedge clk);
		do_reset(1'b0);
		wr_rd_low;
		wrong_addr;
		strap_late;
		strap_high;
		wrap_up;
	end
endmodule
`default_nettype wire
